// *** core/i2ct_pkg.sv ***
package i2ct_pkg;

  // ----------------------------------------------------------------
  // Bus identity
  // ----------------------------------------------------------------
  localparam logic [6:0] TGT_ADDR = 7'h5d;
  // Arbitrary identity value, not tied to any real part
  localparam logic [7:0] ID_VALUE = 8'h5a;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] A_IDENT = 7'h0f;
  localparam logic [6:0] A_CTRL1 = 7'h10;
  localparam logic [6:0] A_CTRL2 = 7'h11;
  localparam logic [6:0] A_CTRL3 = 7'h12;
  localparam logic [6:0] A_OFS_LO = 7'h18;
  localparam logic [6:0] A_OFS_HI = 7'h19;
  localparam logic [6:0] A_RES = 7'h1a;
  localparam logic [6:0] A_STATUS = 7'h27;
  localparam logic [6:0] A_P_LOWEST = 7'h28;
  localparam logic [6:0] A_P_MIDDLE = 7'h29;
  localparam logic [6:0] A_P_UPPER = 7'h2a;
  localparam logic [6:0] A_T_LOW = 7'h2b;
  localparam logic [6:0] A_T_HIGH = 7'h2c;
  localparam logic [6:0] A_FILT = 7'h33;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] R_CTRL1 = 8'h00;
  localparam logic [7:0] R_CTRL2 = 8'h10;
  localparam logic [7:0] R_CTRL3 = 8'h00;
  localparam logic [7:0] R_OFS_LO = 8'h00;
  localparam logic [7:0] R_OFS_HI = 8'h00;
  localparam logic [7:0] R_RES = 8'h00;
  localparam int AUTO_INC_BIT = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] three;
    logic [7:0] ofs_lo;
    logic [7:0] ofs_hi;
    logic [7:0] res;
  } i2ct_ctrl_t;

  typedef struct packed {
    logic [7:0] status;
    logic [23:0] press;
    logic [15:0] temp;
    logic [7:0] filt;
  } i2ct_meas_t;

  typedef struct packed {
    logic we;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic [6:0] raddr;
  } i2ct_req_t;

  typedef enum logic [3:0] {
    LK_IDLE = 4'b0000,
    LK_ADDR = 4'b0001,
    LK_AACK = 4'b0010,
    LK_SUB = 4'b0011,
    LK_SACK = 4'b0100,
    LK_WR = 4'b0101,
    LK_WACK = 4'b0110,
    LK_RD = 4'b0111,
    LK_RACK = 4'b1000,
    LK_IGN = 4'b1001
  } i2ct_lstate_t;

  // Writable register decode
  function automatic logic i2ct_writable(input logic [6:0] a);
    return (a == A_CTRL1) || (a == A_CTRL2) || (a == A_CTRL3) ||
           (a == A_OFS_LO) || (a == A_OFS_HI) || (a == A_RES);
  endfunction

endpackage

// *** core/i2ct_regbank.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2ct_regbank import i2ct_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write port
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output var logic [7:0] rd_data_q,
  // Measurement in, control out
  input wire i2ct_meas_t meas,
  output var i2ct_ctrl_t ctrl_q
);

  // Writable bank; read-only and reserved writes fall through
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= '{R_CTRL1, R_CTRL2, R_CTRL3, R_OFS_LO, R_OFS_HI,
                  R_RES};
    end else if (wr_en) begin
      case (wr_addr)
        A_CTRL1: ctrl_q.one <= wr_data;
        A_CTRL2: ctrl_q.two <= wr_data;
        A_CTRL3: ctrl_q.three <= wr_data;
        A_OFS_LO: ctrl_q.ofs_lo <= wr_data;
        A_OFS_HI: ctrl_q.ofs_hi <= wr_data;
        A_RES: ctrl_q.res <= wr_data;
        default: ;
      endcase
    end
  end

  // Registered read mux; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      case (rd_addr)
        A_IDENT: rd_data_q <= ID_VALUE;
        A_CTRL1: rd_data_q <= ctrl_q.one;
        A_CTRL2: rd_data_q <= ctrl_q.two;
        A_CTRL3: rd_data_q <= ctrl_q.three;
        A_OFS_LO: rd_data_q <= ctrl_q.ofs_lo;
        A_OFS_HI: rd_data_q <= ctrl_q.ofs_hi;
        A_RES: rd_data_q <= ctrl_q.res;
        A_STATUS: rd_data_q <= meas.status;
        A_P_LOWEST: rd_data_q <= meas.press[7:0];
        A_P_MIDDLE: rd_data_q <= meas.press[15:8];
        A_P_UPPER: rd_data_q <= meas.press[23:16];
        A_T_LOW: rd_data_q <= meas.temp[7:0];
        A_T_HIGH: rd_data_q <= meas.temp[15:8];
        A_FILT: rd_data_q <= meas.filt;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ro_write: assert property (@(posedge clk) disable iff (reset)
    (wr_en && !i2ct_writable(wr_addr)) |=> ctrl_q == $past(ctrl_q))
    else $error("read-only write changed the bank");

  a_reset_defaults: assert property (@(posedge clk)
    reset |=> (ctrl_q.two == R_CTRL2) && (ctrl_q.one == R_CTRL1))
    else $error("control defaults not loaded by reset");

endmodule // i2ct_regbank
`default_nettype wire

// *** core/i2ct_target.sv ***
// Notes on behaviour
// - Device is bus target only, registers read/write.
// - Oversampled link works at standard and fast rates.
// - Falling data with clock high starts, bus busy.
// - First byte is address plus direction; exact match.
// - Own address is 1011101 binary.
// - Acknowledge holds data low through clock high.
// - Selected receiver acknowledges every received byte.
// - Sub-address low seven bits select register.
// - Auto-increment bit advances pointer per data byte.
// - Write: address, sub-address, data bytes, stop.
// - Read ends on controller no-acknowledge; release line.
// - Bytes are eight bits, MSB first, unlimited count.
// - Unacknowledged address leaves data line high.
// - Rising data with clock high is stop.
// - Registers are eight bits, seven-bit addressed.
// - Reset reloads the stored register defaults.
`timescale 1ns/1ps
`default_nettype none
module i2ct_target import i2ct_pkg::*; (
  // System clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Link oversampling clock
  input wire logic link_clk,
  // Two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o_q,
  output logic sda_oe_n_q,
  output logic bus_busy_q,
  // Measurement values and control registers
  input wire i2ct_meas_t meas,
  output var i2ct_ctrl_t ctrl_q
);

  // ----------------------------------------------------------------
  // Link domain: reset and pin synchronisers
  // ----------------------------------------------------------------
  logic lrst_s1_q;
  logic link_rst_q;
  logic scl_s1_q, scl_s2_q, scl_p_q;
  logic sda_s1_q, sda_s2_q, sda_p_q;
  logic inc_s1_q, inc_q;
  logic ack_s1_q, ack_s2_q, ack_p_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  // Reset level carried into the link clock
  always_ff @(posedge link_clk) begin
    lrst_s1_q <= reset;
    link_rst_q <= lrst_s1_q;
  end

  // Pins pass two flops before any edge logic sees them
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_p_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_p_q <= sda_s2_q;
    end
  end

  // Auto-increment is quasi-static; a level sync is enough
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      inc_s1_q <= 1'b1;
      inc_q <= 1'b1;
    end else begin
      inc_s1_q <= ctrl_q.two[AUTO_INC_BIT];
      inc_q <= inc_s1_q;
    end
  end

  // Edge and condition detection
  // Oversampling at 48 ns resolves 400 kHz and slower clocks
  assign scl_rise = scl_s2_q & ~scl_p_q;
  assign scl_fall = ~scl_s2_q & scl_p_q;
  assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  // ----------------------------------------------------------------
  // Link domain: protocol engine
  // ----------------------------------------------------------------
  i2ct_lstate_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, tx_q;
  logic rw_q, nack_q;
  logic [6:0] ptr_q, ptr_next;
  logic [7:0] rd_buf_q;
  logic req_tog_q;
  i2ct_req_t req_q;
  logic byte_end, addr_hit;
  logic ack_tog_q;
  logic [7:0] rsp_q;

  assign byte_end = scl_fall & (cnt_q == BITS_PER_BYTE);
  assign addr_hit = (shift_q[7:1] == TGT_ADDR);
  assign ptr_next = inc_q ? 7'(ptr_q + 7'd1) : ptr_q;

  // Bus busy between start and stop
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      bus_busy_q <= 1'b0;
    end else if (start_det) begin
      bus_busy_q <= 1'b1;
    end else if (stop_det) begin
      bus_busy_q <= 1'b0;
    end
  end

  // Sequencing of address, sub-address and data phases
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      state_q <= LK_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b1;
    end else if (start_det) begin
      // Also a repeated start that turns a write into a read
      state_q <= LK_ADDR;
      cnt_q <= 4'h0;
    end else if (stop_det) begin
      state_q <= LK_IDLE;
    end else begin
      if (scl_rise && cnt_q != BITS_PER_BYTE) begin
        shift_q <= {shift_q[6:0], sda_s2_q};
        cnt_q <= 4'(cnt_q + 4'h1);
      end
      if (scl_rise && state_q == LK_RACK) begin
        nack_q <= sda_s2_q;
      end
      unique case (state_q)
        LK_ADDR: if (byte_end) begin
          state_q <= addr_hit ? LK_AACK : LK_IGN;
          rw_q <= shift_q[0];
        end
        LK_AACK: if (scl_fall) begin
          state_q <= rw_q ? LK_RD : LK_SUB;
          cnt_q <= 4'h0;
        end
        LK_SUB: if (byte_end) begin
          state_q <= LK_SACK;
        end
        LK_SACK, LK_WACK: if (scl_fall) begin
          state_q <= LK_WR;
          cnt_q <= 4'h0;
        end
        LK_WR: if (byte_end) begin
          state_q <= LK_WACK;
        end
        LK_RD: if (byte_end) begin
          state_q <= LK_RACK;
        end
        LK_RACK: if (scl_fall) begin
          state_q <= nack_q ? LK_IGN : LK_RD;
          cnt_q <= 4'h0;
        end
        default: ;
      endcase
    end
  end

  // Open-drain data drive; only ever pulls low
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      sda_o_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      tx_q <= 8'h00;
    end else if (start_det || stop_det) begin
      sda_oe_n_q <= 1'b1;
    end else if (scl_fall) begin
      unique case (state_q)
        LK_ADDR: sda_oe_n_q <= ~(byte_end & addr_hit);
        LK_SUB, LK_WR: sda_oe_n_q <= ~byte_end;
        LK_AACK: begin
          tx_q <= rd_buf_q;
          sda_oe_n_q <= rw_q ? rd_buf_q[7] : 1'b1;
        end
        LK_RD: begin
          if (byte_end) begin
            sda_oe_n_q <= 1'b1;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            sda_oe_n_q <= tx_q[6];
          end
        end
        LK_RACK: begin
          tx_q <= rd_buf_q;
          sda_oe_n_q <= nack_q | rd_buf_q[7];
        end
        default: sda_oe_n_q <= 1'b1;
      endcase
    end
  end

  // Pointer and register requests toward the system clock
  // Each request also prefetches the byte a read would send next
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      ptr_q <= 7'h00;
      req_q <= '0;
      req_tog_q <= 1'b0;
    end else if (byte_end && state_q == LK_SUB) begin
      ptr_q <= shift_q[6:0];
      req_q <= '{we: 1'b0, waddr: shift_q[6:0], wdata: 8'h00,
                 raddr: shift_q[6:0]};
      req_tog_q <= ~req_tog_q;
    end else if (byte_end && state_q == LK_WR) begin
      ptr_q <= ptr_next;
      req_q <= '{we: 1'b1, waddr: ptr_q, wdata: shift_q,
                 raddr: ptr_next};
      req_tog_q <= ~req_tog_q;
    end else if (byte_end && state_q == LK_RD) begin
      ptr_q <= ptr_next;
      req_q <= '{we: 1'b0, waddr: ptr_q, wdata: 8'h00,
                 raddr: ptr_next};
      req_tog_q <= ~req_tog_q;
    end
  end

  // Answer toggle comes back through two flops
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_p_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tog_q;
      ack_s2_q <= ack_s1_q;
      ack_p_q <= ack_s2_q;
    end
  end

  // Read buffer; answer word moves with its toggle and is stable before the toggle arrives
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      rd_buf_q <= 8'h00;
    end else if (ack_s2_q ^ ack_p_q) begin
      rd_buf_q <= rsp_q;
    end
  end

  // ----------------------------------------------------------------
  // System domain: request execution
  // ----------------------------------------------------------------
  logic rq_s1_q, rq_s2_q, rq_p_q;
  logic go_q, rd_go_q, cap_q;
  logic [7:0] bank_rdata;
  logic new_req;

  // Request toggle synchroniser
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rq_s1_q <= 1'b0;
      rq_s2_q <= 1'b0;
      rq_p_q <= 1'b0;
    end else begin
      rq_s1_q <= req_tog_q;
      rq_s2_q <= rq_s1_q;
      rq_p_q <= rq_s2_q;
    end
  end

  assign new_req = rq_s2_q ^ rq_p_q;

  // Write first, read one cycle later so a rewrite reads back fresh
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      go_q <= 1'b0;
      rd_go_q <= 1'b0;
      cap_q <= 1'b0;
      rsp_q <= 8'h00;
      ack_tog_q <= 1'b0;
    end else begin
      go_q <= new_req;
      rd_go_q <= go_q;
      cap_q <= rd_go_q;
      if (cap_q) begin
        rsp_q <= bank_rdata;
        ack_tog_q <= ~ack_tog_q;
      end
    end
  end

  // Register bank
  i2ct_regbank u_bank (
    .clk(ref_clk),
    .reset(reset),
    .wr_en(go_q & req_q.we),
    .wr_addr(req_q.waddr),
    .wr_data(req_q.wdata),
    .rd_en(rd_go_q),
    .rd_addr(req_q.raddr),
    .rd_data_q(bank_rdata),
    .meas(meas),
    .ctrl_q(ctrl_q)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_exec;
    ##3 cap_q ##1 (ack_tog_q != $past(ack_tog_q));
  endsequence

  a_req_answer: assert property (@(posedge ref_clk)
    disable iff (reset) new_req |-> s_exec)
    else $error("register request not answered in four cycles");

  a_start_busy: assert property (@(posedge link_clk)
    disable iff (link_rst_q)
    start_det |=> bus_busy_q && state_q == LK_ADDR)
    else $error("start did not mark bus busy");

  a_stop_release: assert property (@(posedge link_clk)
    disable iff (link_rst_q)
    stop_det |=> state_q == LK_IDLE && sda_oe_n_q)
    else $error("stop did not release the link");

  a_addr_ack: assert property (@(posedge link_clk)
    disable iff (link_rst_q)
    (byte_end && state_q == LK_ADDR && addr_hit && !start_det)
      |=> !sda_oe_n_q && state_q == LK_AACK)
    else $error("own address not acknowledged");

  a_foreign_quiet: assert property (@(posedge link_clk)
    disable iff (link_rst_q)
    state_q == LK_IGN |-> sda_oe_n_q)
    else $error("data line driven while not selected");

  a_ack_hold: assert property (@(posedge link_clk)
    disable iff (link_rst_q)
    (state_q inside {LK_AACK, LK_SACK, LK_WACK}) |-> !sda_oe_n_q)
    else $error("acknowledge not held low");

  a_sub_low7: assert property (@(posedge link_clk)
    disable iff (link_rst_q)
    (byte_end && state_q == LK_SUB && !start_det)
      |=> ptr_q == $past(shift_q[6:0]))
    else $error("sub-address not taken from low bits");

  a_ptr_inc: assert property (@(posedge link_clk)
    disable iff (link_rst_q)
    (byte_end && state_q == LK_WR && inc_q && !start_det)
      |=> ptr_q == 7'($past(ptr_q) + 7'd1))
    else $error("pointer did not advance after write");

  a_msb_first: assert property (@(posedge link_clk)
    disable iff (link_rst_q)
    state_q == LK_RD |-> sda_oe_n_q == tx_q[7])
    else $error("read bit does not match shifter head");

endmodule // i2ct_target
`default_nettype wire

// *** verif/i2ct_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2ct_ctl_model (
  // Timing reference
  input wire logic clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Tick length in clk cycles; a bit lasts three ticks plus two cycles; 21 keeps the clock under 400 kHz
  int q = 21;

  // ----------------------------------------------------------------
  // Line primitives
  // ----------------------------------------------------------------
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick();
    repeat (q) @(negedge clk);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start_c();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  // Stop: data rises while the clock is high
  task automatic stop_c();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask

  // One bit; line sampled early and late in the high phase
  task automatic bit_x(input logic b, output logic f, output logic l);
    sda_low = ~b;
    tick();
    scl = 1'b1;
    repeat (2) @(negedge clk);
    f = sda;
    tick();
    l = sda;
    scl = 1'b0;
    tick();
  endtask

  // ----------------------------------------------------------------
  // Byte transfers
  // ----------------------------------------------------------------
  // Ack counts only if low at both the early and the late sample of the high phase
  task automatic wr_byte(input logic [7:0] d, output logic ok);
    logic f;
    logic l;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], f, l);
    end
    bit_x(1'b1, f, l);
    ok = (f === 1'b0) && (l === 1'b0);
  endtask

  // Last byte gets no ack, which also releases the line to the target
  task automatic rd_byte(input logic last_b, output logic [7:0] d,
                         output logic rel);
    logic f;
    logic l;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, f, l);
      d[i] = l;
    end
    bit_x(last_b, f, l);
    rel = l;
  endtask
endmodule // i2ct_ctl_model
`default_nettype wire

// *** verif/test_i2c_target_register_access.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_i2c_target_register_access import i2ct_pkg::*;;
  logic ref_clk;
  logic link_clk;
  logic reset;
  logic scl;
  logic ctl_low;
  logic sda_o_q;
  logic sda_oe_n_q;
  logic bus_busy_q;
  logic [63:0] rnd;
  i2ct_meas_t meas;
  i2ct_ctrl_t ctrl_q;
  i2ct_ctrl_t exp_ctrl;
  int n_mismatch;
  int samples_checked;
  // Open-drain wire: pull-up unless a party pulls low
  wire logic sda_line = ~(ctl_low | (~sda_oe_n_q & ~sda_o_q));

  // Clocks; link clock phase unrelated to the system clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  i2ct_target u_dut (
    .ref_clk(ref_clk), .reset(reset), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda_line), .sda_o_q(sda_o_q), .sda_oe_n_q(sda_oe_n_q),
    .bus_busy_q(bus_busy_q), .meas(meas), .ctrl_q(ctrl_q)
  );
  i2ct_ctl_model u_ctl (
    .clk(ref_clk), .sda(sda_line), .scl(scl), .sda_low(ctl_low)
  );

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_ctrl(input i2ct_ctrl_t got, input i2ct_ctrl_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Expected register contents
  // ----------------------------------------------------------------
  // Unmapped places read back as zero
  function automatic logic [7:0] exp_val(input logic [6:0] a);
    case (a)
      A_IDENT: return ID_VALUE;
      A_CTRL1: return exp_ctrl.one;
      A_CTRL2: return exp_ctrl.two;
      A_CTRL3: return exp_ctrl.three;
      A_OFS_LO: return exp_ctrl.ofs_lo;
      A_OFS_HI: return exp_ctrl.ofs_hi;
      A_RES: return exp_ctrl.res;
      A_STATUS: return meas.status;
      A_P_LOWEST: return meas.press[7:0];
      A_P_MIDDLE: return meas.press[15:8];
      A_P_UPPER: return meas.press[23:16];
      A_T_LOW: return meas.temp[7:0];
      A_T_HIGH: return meas.temp[15:8];
      A_FILT: return meas.filt;
      default: return 8'h00;
    endcase
  endfunction
  // Read-only places keep their content
  function automatic void shadow(input logic [6:0] a, input logic [7:0] d);
    case (a)
      A_CTRL1: exp_ctrl.one = d;
      A_CTRL2: exp_ctrl.two = d;
      A_CTRL3: exp_ctrl.three = d;
      A_OFS_LO: exp_ctrl.ofs_lo = d;
      A_OFS_HI: exp_ctrl.ofs_hi = d;
      A_RES: exp_ctrl.res = d;
      default: ;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus transfers
  // ----------------------------------------------------------------
  task automatic addr_sub(input logic [7:0] sub);
    logic ok;
    u_ctl.start_c();
    check_bit(bus_busy_q, 1'b1);
    u_ctl.wr_byte({TGT_ADDR, 1'b0}, ok);
    check_bit(ok, 1'b1);
    u_ctl.wr_byte(sub, ok);
    check_bit(ok, 1'b1);
  endtask
  // Random data unless rn is low; mapped places only
  task automatic wr_regs(input logic [7:0] sub, input int n, input logic rn,
                         input logic [7:0] v);
    logic ok;
    logic [6:0] a;
    logic [7:0] d;
    a = sub[6:0];
    addr_sub(sub);
    for (int i = 0; i < n; i++) begin
      d = rn ? 8'($urandom()) : v;
      if (rn && a == A_CTRL2) d[AUTO_INC_BIT] = 1'b1;
      u_ctl.wr_byte(d, ok);
      check_bit(ok, 1'b1);
      shadow(a, d);
      if (exp_ctrl.two[AUTO_INC_BIT]) a = a + 7'h01;
    end
    u_ctl.stop_c();
    check_bit(bus_busy_q, 1'b0);
    check_ctrl(ctrl_q, exp_ctrl);
  endtask
  task automatic rd_regs(input logic [7:0] sub, input int n);
    logic ok;
    logic rel;
    logic [6:0] a;
    logic [7:0] d;
    a = sub[6:0];
    addr_sub(sub);
    u_ctl.start_c();
    u_ctl.wr_byte({TGT_ADDR, 1'b1}, ok);
    check_bit(ok, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_ctl.rd_byte(i == n - 1, d, rel);
      check_byte(d, exp_val(a));
      if (exp_ctrl.two[AUTO_INC_BIT]) a = a + 7'h01;
    end
    check_bit(rel, 1'b1);
    u_ctl.stop_c();
  endtask
  task automatic do_reset();
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    exp_ctrl = {R_CTRL1, R_CTRL2, R_CTRL3, R_OFS_LO, R_OFS_HI, R_RES};
    check_ctrl(ctrl_q, exp_ctrl);
    reset = 1'b0;
    // Link side leaves reset two link edges late; look after that
    repeat (10) @(negedge ref_clk);
    check_bit(sda_oe_n_q, 1'b1);
    check_bit(sda_o_q, 1'b0);
    check_bit(bus_busy_q, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Controller only touches mapped registers
  initial begin
    logic ok;
    n_mismatch = 0;
    samples_checked = 0;
    void'($urandom(32'h913082d2));
    meas = '0;
    do_reset();
    rd_regs(8'h0f, 4);
    for (int r = 0; r < 2; r++) begin
      rnd = {$urandom(), $urandom()};
      meas = rnd[55:0];
      wr_regs({r[0], A_CTRL1}, 3, 1'b1, 8'h00);
      wr_regs({~r[0], A_OFS_LO}, 3, 1'b1, 8'h00);
      rd_regs({r[0], A_CTRL1}, 3);
      rd_regs(8'h98, 3);
      rd_regs(8'ha7, 6);
    end
    wr_regs({1'b0, A_STATUS}, 1, 1'b1, 8'h00);
    rd_regs({1'b0, A_STATUS}, 1);
    rd_regs({1'b0, A_FILT}, 1);
    // Auto-increment off: pointer holds, last byte wins
    wr_regs({1'b0, A_CTRL2}, 1, 1'b0, 8'h00);
    rd_regs({1'b0, A_P_LOWEST}, 3);
    wr_regs({1'b0, A_OFS_LO}, 2, 1'b1, 8'h00);
    wr_regs({1'b0, A_CTRL2}, 1, 1'b0, 8'h10);
    // Each single-bit address miss stays silent
    for (int k = 0; k < 7; k++) begin
      u_ctl.start_c();
      u_ctl.wr_byte({TGT_ADDR ^ (7'h01 << k), 1'b0}, ok);
      check_bit(ok, 1'b0);
      u_ctl.wr_byte(8'h00, ok);
      check_bit(ok, 1'b0);
      u_ctl.stop_c();
    end
    // Standard-mode rate
    u_ctl.q = 100;
    wr_regs({1'b0, A_CTRL3}, 1, 1'b1, 8'h00);
    rd_regs({1'b0, A_CTRL3}, 1);
    u_ctl.q = 21;
    do_reset();
    rd_regs({1'b0, A_CTRL1}, 3);
    stop_test();
  end
endmodule // test_i2c_target_register_access
`default_nettype wire
